// *** tsr_pkg.sv ***
// tsr_pkg: register map, field masks, status codes and carrier structs
// for the transmitter status register bank.
// assumes a single 250 MHz clock domain; no other files required.
package tsr_pkg;

  // ------------------------------------------------------------------
  // register addresses (16-bit holding register space)
  // ------------------------------------------------------------------
  localparam logic [15:0] TSR_ADDR_STATUS  = 16'he000;
  localparam logic [15:0] TSR_ADDR_DETAIL  = 16'he001;
  localparam logic [15:0] TSR_ADDR_RELAY_1 = 16'he011;
  localparam logic [15:0] TSR_ADDR_RELAY_2 = 16'he012;

  // ------------------------------------------------------------------
  // detail word masks and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] TSR_MSK_PROBE_ERR  = 16'h0002;
  localparam logic [15:0] TSR_MSK_SUPPLY_LOW = 16'h0004;
  localparam logic [15:0] TSR_MSK_NO_PROBE   = 16'h0010;
  localparam logic [15:0] TSR_MSK_PROBE_WARN = 16'h0020;
  localparam logic [15:0] TSR_RST_WORD       = 16'h0000;
  localparam logic [15:0] TSR_RELAY_OFF      = 16'h0000;
  localparam logic [15:0] TSR_RELAY_ON       = 16'h0001;
  localparam logic [15:0] TSR_UNMAPPED_DATA  = 16'h0000;

  // ------------------------------------------------------------------
  // high-level status codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSR_ST_OK,
    TSR_ST_INFO,
    TSR_ST_WARN,
    TSR_ST_ERROR
  } tsr_status_e;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic probe_err;
    logic supply_low;
    logic no_probe;
    logic probe_warn;
    logic info;
    logic relay_1_on;
    logic relay_2_on;
  } tsr_cond_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
  } tsr_req_s;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] data;
  } tsr_rsp_s;

endpackage

// *** tsr_decode.sv ***
// tsr_decode: maps condition inputs to the status code and detail word.
// assumes conditions are already synchronous to REF_CLK.
module tsr_decode
  import tsr_pkg::*;
(
  input  tsr_cond_s   cond,
  output logic [15:0] status_word,
  output logic [15:0] detail_word
);

  tsr_status_e code;

  // ------------------------------------------------------------------
  // severity: errors outrank warnings, warnings outrank info
  // ------------------------------------------------------------------
  always_comb
  begin
    if (cond.probe_err || cond.no_probe || cond.supply_low)
      code = TSR_ST_ERROR;
    else if (cond.probe_warn)
      code = TSR_ST_WARN;
    else if (cond.info)
      code = TSR_ST_INFO;
    else
      code = TSR_ST_OK;
  end

  assign status_word = {14'h0000, code};

  always_comb
  begin
    detail_word = TSR_RST_WORD;
    if (cond.probe_err)
      detail_word = detail_word | TSR_MSK_PROBE_ERR;
    if (cond.probe_warn)
      detail_word = detail_word | TSR_MSK_PROBE_WARN;
    if (cond.supply_low)
      detail_word = detail_word | TSR_MSK_SUPPLY_LOW;
    if (cond.no_probe)
      detail_word = detail_word | TSR_MSK_NO_PROBE;
  end

endmodule

// *** tsr_bank.sv ***
// tsr_bank: read-only status register bank polled by a field-bus master.
// assumes the protocol front end presents one-cycle read/write strobes
// with a 16-bit register address, synchronous to REF_CLK.

module tsr_bank
  import tsr_pkg::*;
(
  input  logic        REF_CLK,
  input  logic        RST_B,
  input  logic        PROBE_ERR,
  input  logic        SUPPLY_LOW,
  input  logic        NO_PROBE,
  input  logic        PROBE_WARN,
  input  logic        INFO_NOTE,
  input  logic        RELAY_1_ON,
  input  logic        RELAY_2_ON,
  input  logic        RD_STB,
  input  logic        WR_STB,
  input  logic [15:0] ADDR,
  output logic        RD_VALID,
  output logic        RD_HIT,
  output logic [15:0] RD_DATA,
  output logic        WR_REFUSED
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] detail;
    logic [15:0] relay_1;
    logic [15:0] relay_2;
    tsr_rsp_s    rsp;
    logic        wr_refused;
  } tsr_state_s;

  tsr_state_s  state_q;
  tsr_state_s  state_d;
  tsr_cond_s   cond;
  tsr_req_s    req;
  logic [15:0] status_word;
  logic [15:0] detail_word;

  assign cond = '{probe_err:  PROBE_ERR,
                  supply_low: SUPPLY_LOW,
                  no_probe:   NO_PROBE,
                  probe_warn: PROBE_WARN,
                  info:       INFO_NOTE,
                  relay_1_on: RELAY_1_ON,
                  relay_2_on: RELAY_2_ON};
  assign req  = '{rd: RD_STB, wr: WR_STB, addr: ADDR};

  tsr_decode u_decode (
    .cond        (cond),
    .status_word (status_word),
    .detail_word (detail_word)
  );

  function automatic logic [15:0] relay_word(input logic on);
    relay_word = on ? TSR_RELAY_ON : TSR_RELAY_OFF;
  endfunction

  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == TSR_ADDR_STATUS) || (a == TSR_ADDR_DETAIL) ||
                (a == TSR_ADDR_RELAY_1) || (a == TSR_ADDR_RELAY_2);
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    // refreshed every cycle so cleared conditions vanish without any ack
    state_d.status  = status_word;
    state_d.detail  = detail_word;
    state_d.relay_1 = relay_word(cond.relay_1_on);
    state_d.relay_2 = relay_word(cond.relay_2_on);
    state_d.rsp.valid = req.rd;
    state_d.rsp.hit   = req.rd && is_mapped(req.addr);
    state_d.rsp.data  = TSR_UNMAPPED_DATA;
    // read returns the snapshot held at the strobe edge, one cycle latency
    if (req.rd)
    begin
      unique case (req.addr)
        TSR_ADDR_STATUS:  state_d.rsp.data = state_q.status;
        TSR_ADDR_DETAIL:  state_d.rsp.data = state_q.detail;
        TSR_ADDR_RELAY_1: state_d.rsp.data = state_q.relay_1;
        TSR_ADDR_RELAY_2: state_d.rsp.data = state_q.relay_2;
        default:          state_d.rsp.data = TSR_UNMAPPED_DATA;
      endcase
    end
    // writes never touch the bank; a write to a status address is flagged
    // so the front end can answer with an exception
    state_d.wr_refused = req.wr && is_mapped(req.addr);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign RD_VALID   = state_q.rsp.valid;
  assign RD_HIT     = state_q.rsp.hit;
  assign RD_DATA    = state_q.rsp.data;
  assign WR_REFUSED = state_q.wr_refused;

endmodule

// *** tsr_master.sv ***
// tsr_master: field-bus master model issuing strobed register requests.
// assumes the bank takes a request on a rising edge and registers its answer on that same edge.
module tsr_master
  import tsr_pkg::*;
(
  input  logic        REF_CLK,
  output logic        RD_STB,
  output logic        WR_STB,
  output logic [15:0] ADDR
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    RD_STB = 1'b0;
    WR_STB = 1'b0;
    ADDR   = 16'hffff;
  end

  task automatic xfer(logic r, logic w, logic [15:0] ad);
    // one idle edge first, so a release and the next request never share a step
    @(posedge REF_CLK);
    #1;
    RD_STB <= r;
    WR_STB <= w;
    ADDR   <= ad;
    @(posedge REF_CLK);
    #1;
    // the answer stands only until the next edge, so the caller samples it now
    RD_STB <= 1'b0;
    WR_STB <= 1'b0;
    // a released address never keeps its last value
    ADDR   <= ~ad;
  endtask
endmodule

// *** tsr_bank_props.sv ***
// tsr_bank_props: port-level checks of the status register bank.
// assumes one clock; bound to every tsr_bank instance.
module tsr_bank_props
  import tsr_pkg::*;
(
  input logic        REF_CLK,
  input logic        RST_B,
  input logic        PROBE_ERR,
  input logic        SUPPLY_LOW,
  input logic        NO_PROBE,
  input logic        PROBE_WARN,
  input logic        INFO_NOTE,
  input logic        RELAY_1_ON,
  input logic        RELAY_2_ON,
  input logic        RD_STB,
  input logic        WR_STB,
  input logic [15:0] ADDR,
  input logic        RD_VALID,
  input logic        RD_HIT,
  input logic [15:0] RD_DATA,
  input logic        WR_REFUSED
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  // the first edge after reset only loads the snapshot
  logic up_q;
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B) up_q <= 1'b0;
    else up_q <= 1'b1;
  wire st = up_q && RD_STB && ADDR == TSR_ADDR_STATUS;
  wire dt = up_q && RD_STB && ADDR == TSR_ADDR_DETAIL;
  wire wh = ADDR inside {TSR_ADDR_STATUS, TSR_ADDR_DETAIL, TSR_ADDR_RELAY_1, TSR_ADDR_RELAY_2};

  a_rd_answer: assert property (up_q |-> RD_VALID == $past(RD_STB))
    else $error("read answer missing or extra");
  a_st_err: assert property (st && $past(PROBE_ERR | NO_PROBE | SUPPLY_LOW)
    |=> RD_DATA == 16'h0003) else $error("status not error");
  a_st_ok: assert property (st && $past(PROBE_ERR | NO_PROBE | SUPPLY_LOW) == 1'b0
    && $past(PROBE_WARN | INFO_NOTE) == 1'b0 |=> RD_DATA == 16'h0000)
    else $error("status not ok");
  a_det_prb: assert property (dt |=> RD_DATA[1] == $past(PROBE_ERR, 2)
    && RD_DATA[5] == $past(PROBE_WARN, 2)) else $error("probe bits wrong");
  a_det_sup: assert property (dt |=> RD_DATA[2] == $past(SUPPLY_LOW, 2))
    else $error("supply bit wrong");
  a_det_nop: assert property (dt |=> RD_DATA[4] == $past(NO_PROBE, 2))
    else $error("missing probe bit wrong");
  a_det_rsvd: assert property (dt |=> (RD_DATA & 16'hffc9) == 16'h0000)
    else $error("unused detail bit set");
  a_relay_a: assert property (up_q && RD_STB && ADDR == TSR_ADDR_RELAY_1
    |=> RD_DATA == {15'h0000, $past(RELAY_1_ON, 2)}) else $error("relay state wrong");
  a_relay_b: assert property (up_q && RD_STB && ADDR == TSR_ADDR_RELAY_2
    |=> RD_DATA == {15'h0000, $past(RELAY_2_ON, 2)}) else $error("second relay state wrong");
  a_wr_ref: assert property (up_q |-> WR_REFUSED == $past(WR_STB && wh))
    else $error("write refusal wrong");
  c_err: cover property (st ##1 RD_DATA == 16'h0003);
  c_ref: cover property (WR_REFUSED);
  c_miss: cover property (RD_VALID && !RD_HIT);
endmodule

bind tsr_bank tsr_bank_props tsr_bank_props_i (.REF_CLK(REF_CLK), .RST_B(RST_B),
  .PROBE_ERR(PROBE_ERR), .SUPPLY_LOW(SUPPLY_LOW), .NO_PROBE(NO_PROBE), .PROBE_WARN(PROBE_WARN),
  .INFO_NOTE(INFO_NOTE), .RELAY_1_ON(RELAY_1_ON), .RELAY_2_ON(RELAY_2_ON), .RD_STB(RD_STB),
  .WR_STB(WR_STB), .ADDR(ADDR), .RD_VALID(RD_VALID), .RD_HIT(RD_HIT), .RD_DATA(RD_DATA),
  .WR_REFUSED(WR_REFUSED));

// *** testbench.sv ***
// testbench: walks every condition mix, then write attempts and an unmapped read.
// assumes tsr_master and tsr_bank_props are compiled beforehand.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import tsr_pkg::*;
  logic        clk, rst_b, rs, ws, rv, rh, wf;
  logic [15:0] a, d;
  tsr_cond_s   c;
  int          fails, checks;
  logic [15:0] wa [5] = '{TSR_ADDR_STATUS, TSR_ADDR_DETAIL, TSR_ADDR_RELAY_1,
                          TSR_ADDR_RELAY_2, 16'he002};

  tsr_master tsr_master_i (.REF_CLK(clk), .RD_STB(rs), .WR_STB(ws), .ADDR(a));
  tsr_bank tsr_bank_i (.REF_CLK(clk), .RST_B(rst_b), .PROBE_ERR(c.probe_err),
    .SUPPLY_LOW(c.supply_low), .NO_PROBE(c.no_probe), .PROBE_WARN(c.probe_warn),
    .INFO_NOTE(c.info), .RELAY_1_ON(c.relay_1_on), .RELAY_2_ON(c.relay_2_on), .RD_STB(rs),
    .WR_STB(ws), .ADDR(a), .RD_VALID(rv), .RD_HIT(rh), .RD_DATA(d), .WR_REFUSED(wf));

  function automatic logic [15:0] est(tsr_cond_s x);
    return (x.probe_err | x.no_probe | x.supply_low) ? 16'h0003 :
      x.probe_warn ? 16'h0002 : {15'h0000, x.info};
  endfunction
  function automatic logic [15:0] edet(tsr_cond_s x);
    return {10'h000, x.probe_warn, x.no_probe, 1'b0, x.supply_low, x.probe_err, 1'b0};
  endfunction
  task automatic chk(logic [18:0] s, logic [18:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic rd_chk(logic [15:0] ad, logic [15:0] e, logic h);
    tsr_master_i.xfer(1'b1, 1'b0, ad);
    chk({rv, rh, wf, d}, {1'b1, h, 1'b0, e});
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // about 1300 cycles are needed; about nineteen times that is a hang
  initial
  begin
    #100000;
    fails++;
    test_done;
  end
  initial
  begin
    c = '0;
    rst_b = 1'b0;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 128; i++)
    begin
      c = tsr_cond_s'(i[6:0]);
      repeat (2) @(posedge clk);
      #1;
      rd_chk(TSR_ADDR_STATUS, est(c), 1'b1);
      rd_chk(TSR_ADDR_DETAIL, edet(c), 1'b1);
      rd_chk(TSR_ADDR_RELAY_1, {15'h0000, c.relay_1_on}, 1'b1);
      rd_chk(TSR_ADDR_RELAY_2, {15'h0000, c.relay_2_on}, 1'b1);
    end
    $display("test condition mixes done");
    for (int j = 0; j < 5; j++)
    begin
      tsr_master_i.xfer(1'b0, 1'b1, wa[j]);
      chk({rv, rh, wf, d}, {2'b00, j < 4, 16'h0000});
    end
    tsr_master_i.xfer(1'b1, 1'b1, TSR_ADDR_STATUS);
    chk({rv, rh, wf, d}, {3'b111, 16'h0003});
    rd_chk(TSR_ADDR_DETAIL, 16'h0036, 1'b1);
    rd_chk(16'he002, 16'h0000, 1'b0);
    $display("test write attempts done");
    test_done;
  end
endmodule
